// ==== rtl/dpec_pkg.sv ====
package dpec_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = ADDR_W - 2;

  // Register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_A_RISE   = 10'h040;
  localparam logic [IDX_W-1:0] IDX_A_FALL   = 10'h041;
  localparam logic [IDX_W-1:0] IDX_B_RISE   = 10'h042;
  localparam logic [IDX_W-1:0] IDX_B_FALL   = 10'h043;
  localparam logic [IDX_W-1:0] IDX_CONFIG   = 10'h044;
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h045;
  localparam logic [IDX_W-1:0] IDX_GLOBAL   = 10'h046;
  localparam logic [IDX_W-1:0] IDX_PENDING  = 10'h047;
  localparam logic [IDX_W-1:0] IDX_MASK     = 10'h048;
  localparam logic [IDX_W-1:0] IDX_TIMER    = 10'h049;

  // Widths
  localparam int unsigned CAP_W   = 8;
  localparam int unsigned TIMER_W = 12;
  localparam int unsigned NUM_EV  = 4;
  localparam int unsigned NUM_PIN = 2;

  // Event bit positions in flags, enables and capture array
  localparam int unsigned EV_A_RISE = 0;
  localparam int unsigned EV_A_FALL = 1;
  localparam int unsigned EV_B_RISE = 2;
  localparam int unsigned EV_B_FALL = 3;

  // Pin request bit positions in pending and mask
  localparam int unsigned PIN_A = 0;
  localparam int unsigned PIN_B = 1;

  // Prescale codes
  localparam logic [2:0] PRE_MAX = 3'h4;

  // Reset values
  localparam logic [CAP_W-1:0]   CAP_RST   = 8'h00;
  localparam logic [CAP_W-1:0]   CFG_RST   = 8'h00;
  localparam logic [NUM_EV-1:0]  FLAG_RST  = 4'h0;
  localparam logic [NUM_PIN-1:0] PIN_RST   = 2'h0;
  localparam logic [TIMER_W-1:0] TIMER_RST = 12'h000;

  // Timer tick: one microsecond at the pclk rate
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = $clog2(TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  typedef struct packed {
    logic                 hold;
    logic [2:0]           prescale;
    logic [NUM_EV-1:0]    int_en;
  } dpec_cfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } dpec_edge_t;

  // Timer slice chosen by prescale, codes above PRE_MAX act as PRE_MAX
  function automatic logic [CAP_W-1:0] dpec_slice(
    input logic [TIMER_W-1:0] timer,
    input logic [2:0]         pre
  );
    logic [2:0]         sel;
    logic [TIMER_W-1:0] shifted;
    sel     = (pre > PRE_MAX) ? PRE_MAX : pre;
    shifted = timer >> sel;
    return shifted[CAP_W-1:0];
  endfunction : dpec_slice

endpackage : dpec_pkg

// ==== rtl/dpec_pin_sync.sv ====
module dpec_pin_sync (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                pin_async,
  output dpec_pkg::dpec_edge_t     edges
);
  import dpec_pkg::*;

  logic meta;
  logic samp;
  logic samp_d;
  logic level;
  logic armed;
  logic agree;
  logic [2:0] fill;

  // Marks stages that hold real pin samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= '0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      samp   <= 1'b0;
      samp_d <= 1'b0;
    end else begin
      meta   <= pin_async;
      samp   <= meta;
      samp_d <= samp;
    end
  end

  assign agree = (samp == samp_d);

  // Settled level, first real agreement only arms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      armed <= 1'b0;
    end else if (agree && fill[2]) begin
      level <= samp_d;
      armed <= 1'b1;
    end
  end

  assign edges.rise = armed & agree & samp_d & ~level;
  assign edges.fall = armed & agree & ~samp_d & level;

endmodule : dpec_pin_sync

// ==== rtl/dpec_top.sv ====
// Operation
// - Four 8-bit rise/fall captures, pins A, B
// - Matching edge loads timer slice into register
// - Capture registers read-only, zero after reset
// - Flags: 3 B fall, 2 B rise, 1 A fall, 0 A rise
// - Reading capture clears only its own flag
// - Pin A events one request, pin B another
// - Config bits 3:0 enable each event interrupt
// - Interrupt needs event and global enable
// - Hold mode keeps first edge until read
// - Default mode keeps latest edge time
// - One hold bit governs all four captures
// - Prescale 0 to 4 selects bits 7:0 to 11:4
// - Timer advances once per microsecond
// - Reset clears all interrupt enables
// - Request pends until serviced or reset
module dpec_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dpec_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [dpec_pkg::DATA_W-1:0]  pwdata,
  output logic      [dpec_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         capture_pin_a,
  input  wire logic                         capture_pin_b,
  output logic                              cap_irq_a,
  output logic                              cap_irq_b,
  output logic                              irq
);
  import dpec_pkg::*;

  dpec_edge_t                     edge_a;
  dpec_edge_t                     edge_b;
  logic       [NUM_EV-1:0]        ev;
  dpec_cfg_t                      cfg;
  logic       [NUM_EV-1:0]        flags;
  logic       [CAP_W-1:0]         cap [NUM_EV];
  logic       [TIMER_W-1:0]       free_timer;
  logic       [TICK_W-1:0]        tick_cnt;
  logic                           tick;
  logic       [CAP_W-1:0]         slice;
  logic                           glob_en;
  logic       [NUM_PIN-1:0]       pending;
  logic       [NUM_PIN-1:0]       mask;
  logic       [NUM_PIN-1:0]       req;
  logic       [NUM_PIN-1:0]       irq_line;
  logic       [IDX_W-1:0]         idx;
  logic                           aligned;
  logic                           setup;
  logic                           access;
  logic                           wr_en;
  logic       [NUM_EV-1:0]        rd_clr;
  logic       [NUM_EV-1:0]        accept;
  logic       [DATA_W-1:0]        next_prdata;
  logic                           hit;

  function automatic logic dpec_mapped(input logic [IDX_W-1:0] i);
    return (i >= IDX_A_RISE) && (i <= IDX_TIMER);
  endfunction : dpec_mapped

  function automatic logic dpec_wr_to(input logic [IDX_W-1:0] i);
    return wr_en && (idx == i);
  endfunction : dpec_wr_to

  dpec_pin_sync u_sync_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (capture_pin_a),
    .edges     (edge_a)
  );

  dpec_pin_sync u_sync_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (capture_pin_b),
    .edges     (edge_b)
  );

  assign ev[EV_A_RISE] = edge_a.rise;
  assign ev[EV_A_FALL] = edge_a.fall;
  assign ev[EV_B_RISE] = edge_b.rise;
  assign ev[EV_B_FALL] = edge_b.fall;

  // microsecond tick for the free timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_timer <= TIMER_RST;
    end else if (tick) begin
      free_timer <= free_timer + TIMER_W'(1);
    end
  end

  assign slice = dpec_slice(free_timer, cfg.prescale);

  // Bus decode
  assign idx     = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit     = aligned && dpec_mapped(idx);
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign wr_en   = access && pwrite && hit;

  // read of a capture clears its own flag
  always_comb begin
    rd_clr = '0;
    for (int i = 0; i < NUM_EV; i++) begin
      rd_clr[i] = setup && !pwrite && aligned
                  && (idx == IDX_A_RISE + IDX_W'(i));
    end
  end

  // No wait state, answer registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (setup) begin
        prdata <= pwrite ? '0 : next_prdata;
      end
    end
  end

  // Read mux
  always_comb begin
    next_prdata = '0;
    if (aligned) begin
      unique case (idx)
        IDX_A_RISE:  next_prdata[CAP_W-1:0] = cap[EV_A_RISE];
        IDX_A_FALL:  next_prdata[CAP_W-1:0] = cap[EV_A_FALL];
        IDX_B_RISE:  next_prdata[CAP_W-1:0] = cap[EV_B_RISE];
        IDX_B_FALL:  next_prdata[CAP_W-1:0] = cap[EV_B_FALL];
        IDX_CONFIG:  next_prdata[CAP_W-1:0] = cfg;
        IDX_FLAGS:   next_prdata[NUM_EV-1:0] = flags;
        IDX_GLOBAL:  next_prdata[0] = glob_en;
        IDX_PENDING: next_prdata[NUM_PIN-1:0] = pending;
        IDX_MASK:    next_prdata[NUM_PIN-1:0] = mask;
        IDX_TIMER:   next_prdata[TIMER_W-1:0] = free_timer;
        default:     next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RST;
    end else if (dpec_wr_to(IDX_CONFIG)) begin
      cfg <= pwdata[CAP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob_en <= 1'b0;
      mask    <= PIN_RST;
    end else begin
      if (dpec_wr_to(IDX_GLOBAL)) begin
        glob_en <= pwdata[0];
      end
      if (dpec_wr_to(IDX_MASK)) begin
        mask <= pwdata[NUM_PIN-1:0];
      end
    end
  end

  // hold blocks loads while flag stands
  // single hold bit for all captures
  always_comb begin
    for (int i = 0; i < NUM_EV; i++) begin
      accept[i] = ev[i] && (!cfg.hold || !flags[i] || rd_clr[i]);
    end
  end

  // captures zero at reset, no bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_EV; i++) begin
        cap[i] <= CAP_RST;
      end
    end else begin
      for (int i = 0; i < NUM_EV; i++) begin
        if (accept[i]) begin
          cap[i] <= slice;
        end
      end
    end
  end

  // edge sets its flag, set beats read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAG_RST;
    end else begin
      for (int i = 0; i < NUM_EV; i++) begin
        if (ev[i]) begin
          flags[i] <= 1'b1;
        end else if (rd_clr[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  assign req[PIN_A] = |(ev[EV_A_FALL:EV_A_RISE]
                        & cfg.int_en[EV_A_FALL:EV_A_RISE]);
  assign req[PIN_B] = |(ev[EV_B_FALL:EV_B_RISE]
                        & cfg.int_en[EV_B_FALL:EV_B_RISE]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= PIN_RST;
    end else begin
      for (int p = 0; p < NUM_PIN; p++) begin
        if (req[p]) begin
          pending[p] <= 1'b1;
        end else if (dpec_wr_to(IDX_PENDING) && pwdata[p]) begin
          pending[p] <= 1'b0;
        end
      end
    end
  end

  assign irq_line  = pending & mask & {NUM_PIN{glob_en}};
  assign cap_irq_a = irq_line[PIN_A];
  assign cap_irq_b = irq_line[PIN_B];
  assign irq       = |irq_line;

  default clocking dpec_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_flag_set: assert property (
    ev[EV_B_FALL] |=> flags[EV_B_FALL]
  ) else $error("B fall flag not set after edge");

  a_read_clears: assert property (
    rd_clr[EV_A_RISE] && !ev[EV_A_RISE] |=> !flags[EV_A_RISE]
  ) else $error("A rise flag not cleared by read");

  a_others_kept: assert property (
    rd_clr[EV_A_RISE] && ev == '0
    |=> flags[NUM_EV-1:1] == $past(flags[NUM_EV-1:1])
  ) else $error("read disturbed other flags");

  a_latest_edge: assert property (
    !cfg.hold && ev[EV_A_FALL] |=> cap[EV_A_FALL] == $past(slice)
  ) else $error("latest edge time not captured");

  a_hold_first: assert property (
    cfg.hold && flags[EV_B_RISE] && !rd_clr[EV_B_RISE]
    |=> $stable(cap[EV_B_RISE])
  ) else $error("held capture changed");

  a_slice_pre: assert property (
    cfg.prescale == 3'h2 |-> slice == free_timer[CAP_W+1:2]
  ) else $error("wrong timer slice");

  a_req_merge: assert property (
    ev[EV_A_RISE] && cfg.int_en[EV_A_RISE] && !req[PIN_B]
    |=> pending[PIN_A] && !$rose(pending[PIN_B])
  ) else $error("A event did not pend A alone");

  a_irq_gate: assert property (
    irq |-> glob_en && |(pending & mask)
  ) else $error("interrupt without enables");

  a_pend_hold: assert property (
    pending[PIN_B] && !dpec_wr_to(IDX_PENDING) |=> pending[PIN_B]
  ) else $error("pending dropped without service");

  a_tick_space: assert property (
    tick |=> !tick [*8]
  ) else $error("timer ticks too close");

  a_rsvd_zero: assert property (
    pready && !pwrite && idx == IDX_FLAGS |-> prdata[CAP_W-1:NUM_EV] == '0
  ) else $error("reserved flag bits not zero");

  a_flags_read: assert property (
    pready && !pwrite && aligned && idx == IDX_FLAGS
    |-> prdata[NUM_EV-1:0] == $past(flags)
  ) else $error("flag read returned wrong bits");

  a_ro_capture: assert property (
    wr_en && idx == IDX_A_RISE && !ev[EV_A_RISE] |=> $stable(cap[EV_A_RISE])
  ) else $error("bus write changed a capture");

  a_pend_cause: assert property (
    $rose(pending[PIN_A])
    |-> $past(|(ev[EV_A_FALL:EV_A_RISE] & cfg.int_en[EV_A_FALL:EV_A_RISE]))
  ) else $error("A request pended without enabled event");

  a_timer_step: assert property (
    tick |=> free_timer == $past(free_timer) + TIMER_W'(1)
  ) else $error("free timer did not step");

  a_hold_all: assert property (
    cfg.hold && flags[EV_A_FALL] && !rd_clr[EV_A_FALL]
    |=> $stable(cap[EV_A_FALL])
  ) else $error("held A fall capture changed");

  c_hold_capture: cover property (
    cfg.hold && ev[EV_A_RISE] && flags[EV_A_RISE]
  );
  c_read_edge_clash: cover property (
    rd_clr[EV_B_FALL] && ev[EV_B_FALL]
  );
  c_irq_b: cover property (
    $rose(cap_irq_b)
  );
  c_max_prescale: cover property (
    cfg.prescale == PRE_MAX && ev[EV_A_FALL]
  );
  c_prescale_clamp: cover property (
    cfg.prescale > PRE_MAX && ev[EV_B_RISE]
  );

endmodule : dpec_top

// ==== testbench/dpec_pins.sv ====
module dpec_pins (
  input  wire logic pclk,
  output logic      pin_a,
  output logic      pin_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // Change after an edge, hold past the sync chain
  task automatic flip(input int p);
    @(posedge pclk);
    if (p == 0) pin_a <= ~pin_a;
    else pin_b <= ~pin_b;
    repeat (6) @(posedge pclk);
  endtask : flip
endmodule : dpec_pins

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpec_pkg::*;

  localparam logic [11:0] CAP0 = {IDX_A_RISE, 2'b00};
  localparam logic [11:0] CFG  = {IDX_CONFIG, 2'b00};
  localparam logic [11:0] FLG  = {IDX_FLAGS, 2'b00};
  localparam logic [11:0] GLB  = {IDX_GLOBAL, 2'b00};
  localparam logic [11:0] PND  = {IDX_PENDING, 2'b00};
  localparam logic [11:0] MSK  = {IDX_MASK, 2'b00};
  localparam logic [11:0] TMR  = {IDX_TIMER, 2'b00};

  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pin_a, pin_b, irq_a, irq_b, irq, er;
  int          mismatches, compares, cyc;
  int          seed = 59564;
  logic [7:0]  m_cap [4];
  logic [7:0]  m_cfg;
  logic [3:0]  m_flag;
  logic [1:0]  m_pend, m_mask;
  logic        m_glob;

  dpec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_a(pin_a), .capture_pin_b(pin_b), .cap_irq_a(irq_a),
    .cap_irq_b(irq_b), .irq(irq));
  dpec_pins u_pins (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] cad(input int i);
    return CAP0 + 12'(4 * i);
  endfunction : cad

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
    if (a[11:4] == CAP0[11:4]) m_flag[a[3:2]] = 1'b0;
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  function automatic logic [7:0] slc(input logic [11:0] t);
    logic [11:0] x;
    x = t >> ((m_cfg[6:4] > 3'h4) ? 3'h4 : m_cfg[6:4]);
    return x[7:0];
  endfunction : slc

  // Poll the timer until it steps, r then holds the new value
  task automatic wait_tick;
    logic [31:0] t0;
    apb(1'b0, TMR, 32'h0);
    t0 = r;
    do begin
      apb(1'b0, TMR, 32'h0);
    end while (r == t0);
  endtask : wait_tick

  // Two timer steps one microsecond apart
  task automatic tick_gap;
    logic [31:0] t1;
    int          c0;
    int          gap;
    logic        in_range;
    wait_tick();
    t1 = r;
    c0 = cyc;
    wait_tick();
    gap = cyc - c0;
    in_range = (gap >= TICK_CYC - 3) && (gap <= TICK_CYC + 3);
    check(r, t1 + 32'h1);
    check({31'h0, in_range}, 32'h1);
  endtask : tick_gap

  // Flip a pin right after a timer tick so the capture is known
  task automatic edge_ev(input int p);
    int          e;
    wait_tick();
    u_pins.flip(p);
    e = 2 * p + (((p == 0) ? pin_a : pin_b) ? 0 : 1);
    if (!(m_cfg[7] && m_flag[e])) m_cap[e] = slc(r[11:0]);
    m_flag[e] = 1'b1;
    if (m_cfg[e]) m_pend[p] = 1'b1;
  endtask : edge_ev

  task automatic chk_state;
    rd(FLG, {28'h0, m_flag});
    check({29'h0, irq_a, irq_b, irq}, {29'h0, m_pend[0] & m_mask[0] & m_glob,
      m_pend[1] & m_mask[1] & m_glob, |(m_pend & m_mask) & m_glob});
  endtask : chk_state

  task automatic caps;
    for (int e = 0; e < 4; e++) begin
      rd(cad(e), {24'h0, m_cap[e]});
      rd(FLG, {28'h0, m_flag});
    end
  endtask : caps

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    m_cap = '{8'h00, 8'h00, 8'h00, 8'h00};
    {m_cfg, m_flag, m_pend, m_mask, m_glob} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(cad(i), 32'h0);
    rd(GLB, 32'h0);
    rd(MSK, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    check({31'h0, er}, 32'h1);
    tick_gap();
    $display("reset test done");
    for (int p = 0; p < 6; p++) begin
      m_cfg = {1'b0, 3'(p), 4'($random(seed))};
      wr(CFG, {24'h0, m_cfg});
      rd(CFG, {24'h0, m_cfg});
      for (int k = 0; k < 4; k++) edge_ev(k / 2);
      chk_state();
      rd(PND, {30'h0, m_pend});
      caps();
    end
    $display("prescale test done");
    for (int i = 0; i < 6; i++) begin
      if (i != 4) wr(cad(i), $random(seed));
    end
    caps();
    rd(FLG, {28'h0, m_flag});
    $display("read-only test done");
    m_cfg = 8'h0d;
    wr(CFG, {24'h0, m_cfg});
    wr(PND, 32'h3);
    m_pend = 2'b00;
    edge_ev(0);
    edge_ev(0);
    chk_state();
    wr(GLB, 32'h1);
    m_glob = 1'b1;
    chk_state();
    wr(MSK, 32'h3);
    m_mask = 2'b11;
    edge_ev(1);
    chk_state();
    wr(PND, 32'h1);
    m_pend[0] = 1'b0;
    chk_state();
    $display("interrupt test done");
    m_cfg = 8'h80;
    wr(CFG, {24'h0, m_cfg});
    for (int k = 0; k < 6; k++) edge_ev(k % 2);
    caps();
    edge_ev(0);
    edge_ev(1);
    caps();
    m_cfg = 8'h00;
    wr(CFG, 32'h0);
    edge_ev(0);
    edge_ev(0);
    edge_ev(0);
    caps();
    $display("hold test done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(FLG, 32'h0);
    rd(cad(0), 32'h0);
    rd(GLB, 32'h0);
    rd(PND, 32'h0);
    $display("second reset test done");
    give_verdict();
  end
endmodule : tb
